// ==== hdl/arf_pkg.sv ====
// Constants, types and decode functions of the application register file
package arf_pkg;

  // ==========================================================================
  // Widths and register numbers
  localparam int DATA_W = 64;
  localparam int NUM_W = 7;
  localparam int AR_COUNT = 128;

  localparam logic [6:0] AR_KR_LAST = 7'h07;
  localparam logic [6:0] AR_RSC = 7'h10;
  localparam logic [6:0] AR_SAP = 7'h11;
  localparam logic [6:0] AR_SSP = 7'h12;
  localparam logic [6:0] AR_SDB = 7'h13;
  localparam logic [6:0] AR_LFPC = 7'h15;
  localparam logic [6:0] AR_LFLAGS = 7'h18;
  localparam logic [6:0] AR_CSD = 7'h19;
  localparam logic [6:0] AR_SSD = 7'h1a;
  localparam logic [6:0] AR_COMBINED_CTRL_FLAGS = 7'h1b;
  localparam logic [6:0] AR_LFPS = 7'h1c;
  localparam logic [6:0] AR_LFPI = 7'h1d;
  localparam logic [6:0] AR_LFPD = 7'h1e;
  localparam logic [6:0] AR_CMPX = 7'h20;
  localparam logic [6:0] AR_UDB = 7'h24;
  localparam logic [6:0] AR_FSC = 7'h28;
  localparam logic [6:0] AR_ITC = 7'h2c;
  localparam logic [6:0] AR_M_LAST = 7'h2f;
  localparam logic [6:0] AR_IGN_LO_FIRST = 7'h30;
  localparam logic [6:0] AR_IGN_LO_LAST = 7'h3f;
  localparam logic [6:0] AR_PFS = 7'h40;
  localparam logic [6:0] AR_LPC = 7'h41;
  localparam logic [6:0] AR_EPC = 7'h42;
  localparam logic [6:0] AR_IGN_HI_FIRST = 7'h70;
  localparam logic [1:0] KR_LEGACY_LAST = 2'h2;

  // ==========================================================================
  // Privilege, field layout, masks, reset values
  localparam logic [1:0] PL_MOST = 2'h0;
  localparam int RSC_EAGER_ST_BIT = 0;
  localparam int RSC_EAGER_LD_BIT = 1;
  localparam int RSC_PL_LSB = 2;
  localparam int RSC_PL_MSB = 3;
  localparam int RSC_BE_BIT = 4;
  localparam int RSC_RLD_LSB = 16;
  localparam int RSC_RLD_MSB = 29;
  localparam logic [63:0] RSC_IMPL_MASK = 64'h0000_0000_3fff_001f;
  localparam logic [63:0] EC_MASK = 64'h0000_0000_0000_003f;
  localparam logic [63:0] SDB_MASK = 64'h7fff_ffff_ffff_ffff;
  localparam logic [63:0] ALL_ONES = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] LFLAGS_PRIV_MASK = 64'h0000_0000_0000_3200;
  localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;

  // ==========================================================================
  // Types
  typedef enum logic [0:0] {UNIT_M = 1'b0, UNIT_I = 1'b1} exec_unit_t;

  typedef enum logic [2:0] {
    CLS_KR = 3'h0, CLS_RSC = 3'h1, CLS_SAP = 3'h2, CLS_STORE = 3'h3,
    CLS_LFLAGS = 3'h4, CLS_COMBINED_CTRL_FLAGS = 3'h5, CLS_IGN = 3'h6, CLS_RSV = 3'h7
  } ar_class_t;

  typedef struct packed {
    logic valid;
    logic write;
    exec_unit_t unit;
    logic [6:0] num;
    logic [63:0] wdata;
  } move_req_t;

  typedef struct packed {
    logic valid;
    logic [63:0] rdata;
    logic unit_fault;
    logic illegal_fault;
    logic priv_fault;
  } move_rsp_t;

  typedef struct packed {
    logic eager_load;
    logic eager_store;
    logic [1:0] engine_priv_level;
    logic engine_byte_order;
    logic [13:0] reload_distance;
  } engine_cfg_t;

  typedef struct packed {
    logic valid;
    logic [1:0] idx;
    logic [63:0] data;
  } legacy_wr_t;

  typedef struct packed {
    logic valid;
    logic [63:0] value;
  } engine_upd_t;

  localparam engine_cfg_t CFG_RESET = '0;

  // ==========================================================================
  // Decode functions
  function automatic ar_class_t ar_classify(input logic [6:0] num);
    ar_class_t c;
    c = CLS_RSV;
    if (num <= AR_KR_LAST) begin
      c = CLS_KR;
    end else if ((num >= AR_IGN_LO_FIRST && num <= AR_IGN_LO_LAST) || num >= AR_IGN_HI_FIRST) begin
      c = CLS_IGN;
    end else begin
      case (num)
        AR_RSC: c = CLS_RSC;
        AR_SAP: c = CLS_SAP;
        AR_LFLAGS: c = CLS_LFLAGS;
        AR_COMBINED_CTRL_FLAGS: c = CLS_COMBINED_CTRL_FLAGS;
        AR_SSP, AR_SDB, AR_LFPC, AR_CSD, AR_SSD, AR_LFPS, AR_LFPI, AR_LFPD,
        AR_CMPX, AR_UDB, AR_FSC, AR_ITC, AR_PFS, AR_LPC, AR_EPC: c = CLS_STORE;
        default: c = CLS_RSV;
      endcase
    end
    return c;
  endfunction

  function automatic logic unit_allowed(input logic [6:0] num, input exec_unit_t unit);
    logic ok;
    ok = 1'b1;
    if (ar_classify(num) == CLS_IGN) begin
      ok = 1'b1;
    end else if (num <= AR_M_LAST) begin
      ok = (unit == UNIT_M);
    end else begin
      ok = (unit == UNIT_I);
    end
    return ok;
  endfunction

  function automatic logic [63:0] write_mask(input logic [6:0] num);
    logic [63:0] m;
    m = ALL_ONES;
    if (num == AR_EPC) begin
      m = EC_MASK;
    end else if (num == AR_SDB) begin
      m = SDB_MASK;
    end
    return m;
  endfunction

  function automatic logic [63:0] rsc_pack(input engine_cfg_t cfg);
    logic [63:0] w;
    w = '0;
    w[RSC_EAGER_ST_BIT] = cfg.eager_store;
    w[RSC_EAGER_LD_BIT] = cfg.eager_load;
    w[RSC_PL_MSB:RSC_PL_LSB] = cfg.engine_priv_level;
    w[RSC_BE_BIT] = cfg.engine_byte_order;
    w[RSC_RLD_MSB:RSC_RLD_LSB] = cfg.reload_distance;
    return w;
  endfunction

endpackage

// ==== hdl/arf_storage.sv ====
// Plain word storage of the application registers, registered read
`timescale 1ns/10ps
module arf_storage (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [63:0] wr_data,
  input wire logic [6:0] rd_addr,
  output logic [63:0] rd_data_r
);
  import arf_pkg::*;

  // ==========================================================================
  // Array and ports
  logic [63:0] mem [0:AR_COUNT-1];
  logic [63:0] rd_data_nxt;

  always_comb begin
    rd_data_nxt = mem[rd_addr];
  end

  // Read sees the old word when written in the same cycle
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= REG_RESET;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end
endmodule // arf_storage

// ==== hdl/application_register_file.sv ====
// Application register file: move decode, privilege checks, engine configuration
//
// Functional notes
// - Eight 64-bit kernel info registers; read at any level, written only at level 0.
// - Kernel info or combined flags write at nonzero level raises privileged fault.
// - Numbers to 47 need memory unit, 64 up integer unit, ignored either.
// - Nonzero level: protected legacy flags bits keep old value, no fault.
// - Kernel info registers 0-2 also hold legacy state while legacy code runs.
// - Stack configuration register is 64 bits and steers the spill/fill engine.
// - Written engine privilege never more privileged than current level.
// - Mode bit 1 enables eager loads, bit 0 eager stores.
// - Eager modes are hints only; lazy behaviour is always legal.
// - Engine memory accesses use the configured privilege level.
// - Engine byte order: 0 little endian, 1 big endian.
// - Fourteen-bit reload distance held for stack reload synchronisation.
// - Spill area pointer is read-only to register moves.
`timescale 1ns/10ps
module application_register_file (
  input wire logic clk,
  input wire logic rst_n,
  input arf_pkg::move_req_t move_req,
  input wire logic [1:0] cur_priv_level,
  input wire logic legacy_active,
  input arf_pkg::legacy_wr_t legacy_wr,
  input arf_pkg::engine_upd_t engine_upd,
  output arf_pkg::move_rsp_t move_rsp,
  output arf_pkg::engine_cfg_t engine_cfg,
  output logic [63:0] spill_area_pointer
);
  import arf_pkg::*;

  // ==========================================================================
  // Request decode
  ar_class_t cls;
  logic unit_ok;
  logic is_wr;
  logic unit_fault;
  logic illegal_fault;
  logic priv_fault;
  logic wr_ok;
  logic [63:0] masked_wdata;

  always_comb begin
    cls = ar_classify(move_req.num);
    unit_ok = unit_allowed(move_req.num, move_req.unit);
    is_wr = move_req.valid && move_req.write;
    unit_fault = move_req.valid && !unit_ok;
    illegal_fault = move_req.valid && unit_ok && (cls == CLS_RSV || (move_req.write && cls == CLS_SAP));
    priv_fault = is_wr && unit_ok && (cls == CLS_KR || cls == CLS_COMBINED_CTRL_FLAGS) && (cur_priv_level != PL_MOST);
    wr_ok = is_wr && !unit_fault && !illegal_fault && !priv_fault;
    masked_wdata = move_req.wdata & write_mask(move_req.num);
  end

  // ==========================================================================
  // Configuration, legacy flags and spill area pointer
  engine_cfg_t cfg_r;
  engine_cfg_t cfg_nxt;
  logic [63:0] lflags_r;
  logic [63:0] lflags_nxt;
  logic [63:0] sap_r;
  logic [63:0] sap_nxt;
  logic [63:0] rsc_w;

  always_comb begin
    cfg_nxt = cfg_r;
    lflags_nxt = lflags_r;
    sap_nxt = sap_r;
    rsc_w = move_req.wdata & RSC_IMPL_MASK;
    if (wr_ok && cls == CLS_RSC) begin
      cfg_nxt.eager_load = rsc_w[RSC_EAGER_LD_BIT];
      cfg_nxt.eager_store = rsc_w[RSC_EAGER_ST_BIT];
      // Higher number means less privilege, so clamp upward
      if (rsc_w[RSC_PL_MSB:RSC_PL_LSB] < cur_priv_level) begin
        cfg_nxt.engine_priv_level = cur_priv_level;
      end else begin
        cfg_nxt.engine_priv_level = rsc_w[RSC_PL_MSB:RSC_PL_LSB];
      end
      cfg_nxt.engine_byte_order = rsc_w[RSC_BE_BIT];
      cfg_nxt.reload_distance = rsc_w[RSC_RLD_MSB:RSC_RLD_LSB];
    end
    if (wr_ok && cls == CLS_LFLAGS) begin
      if (cur_priv_level == PL_MOST) begin
        lflags_nxt = move_req.wdata;
      end else begin
        lflags_nxt = (move_req.wdata & ~LFLAGS_PRIV_MASK) | (lflags_r & LFLAGS_PRIV_MASK);
      end
    end
    // Only the engine moves this pointer
    if (engine_upd.valid) begin
      sap_nxt = engine_upd.value;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RESET;
      lflags_r <= REG_RESET;
      sap_r <= REG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
      lflags_r <= lflags_nxt;
      sap_r <= sap_nxt;
    end
  end

  // Eager bits go out as hints; a lazy engine may ignore them
  assign engine_cfg = cfg_r;
  assign spill_area_pointer = sap_r;

  // ==========================================================================
  // Storage write port
  logic mem_we;
  logic [6:0] mem_waddr;
  logic [63:0] mem_wdata;
  logic [63:0] mem_q;

  // Legacy code issues no moves, so the legacy port owns the write side then
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = move_req.num;
    mem_wdata = masked_wdata;
    if (legacy_active) begin
      mem_we = legacy_wr.valid && (legacy_wr.idx <= KR_LEGACY_LAST);
      mem_waddr = {5'h00, legacy_wr.idx};
      mem_wdata = legacy_wr.data;
    end else begin
      mem_we = wr_ok && (cls == CLS_KR || cls == CLS_STORE || cls == CLS_COMBINED_CTRL_FLAGS);
    end
  end

  arf_storage u_storage (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(move_req.num),
    .rd_data_r(mem_q)
  );

  // ==========================================================================
  // Two-stage answer pipeline
  logic s1_valid_r;
  logic s1_valid_nxt;
  logic s1_use_mem_r;
  logic s1_use_mem_nxt;
  logic [63:0] s1_val_r;
  logic [63:0] s1_val_nxt;
  logic [2:0] s1_flt_r;
  logic [2:0] s1_flt_nxt;
  move_rsp_t rsp_r;
  move_rsp_t rsp_nxt;
  logic rd_ok;

  always_comb begin
    rd_ok = move_req.valid && !move_req.write && !unit_fault && !illegal_fault;
    s1_valid_nxt = move_req.valid;
    s1_flt_nxt = {unit_fault, illegal_fault, priv_fault};
    s1_use_mem_nxt = rd_ok && (cls == CLS_KR || cls == CLS_STORE || cls == CLS_COMBINED_CTRL_FLAGS);
    s1_val_nxt = REG_RESET;
    if (rd_ok) begin
      case (cls)
        CLS_RSC: s1_val_nxt = rsc_pack(cfg_r);
        CLS_SAP: s1_val_nxt = sap_r;
        CLS_LFLAGS: s1_val_nxt = lflags_r;
        default: s1_val_nxt = REG_RESET;
      endcase
    end
    rsp_nxt.valid = s1_valid_r;
    rsp_nxt.rdata = s1_use_mem_r ? mem_q : s1_val_r;
    rsp_nxt.unit_fault = s1_valid_r && s1_flt_r[2];
    rsp_nxt.illegal_fault = s1_valid_r && s1_flt_r[1];
    rsp_nxt.priv_fault = s1_valid_r && s1_flt_r[0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_valid_r <= 1'b0;
      s1_use_mem_r <= 1'b0;
      s1_val_r <= REG_RESET;
      s1_flt_r <= 3'h0;
      rsp_r <= '0;
    end else begin
      s1_valid_r <= s1_valid_nxt;
      s1_use_mem_r <= s1_use_mem_nxt;
      s1_val_r <= s1_val_nxt;
      s1_flt_r <= s1_flt_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign move_rsp = rsp_r;

  // ==========================================================================
  // Checks
  property p_kr_write_priv;
    @(posedge clk) disable iff (!rst_n)
      (move_req.valid && move_req.write && move_req.unit == UNIT_M && move_req.num <= AR_KR_LAST
       && cur_priv_level != PL_MOST) |-> ##2 (move_rsp.valid && move_rsp.priv_fault);
  endproperty
  a_kr_write_priv: assert property (p_kr_write_priv) else $error("kernel info write at low privilege not faulted");

  property p_read_never_priv;
    @(posedge clk) disable iff (!rst_n)
      (move_req.valid && !move_req.write) |-> ##2 !move_rsp.priv_fault;
  endproperty
  a_read_never_priv: assert property (p_read_never_priv) else $error("read raised privileged fault");

  property p_combined_ctrl_flags_write_priv;
    @(posedge clk) disable iff (!rst_n)
      (move_req.valid && move_req.write && move_req.unit == UNIT_M && move_req.num == AR_COMBINED_CTRL_FLAGS
       && cur_priv_level != PL_MOST) |-> ##1 s1_flt_r[0] ##1 (move_rsp.priv_fault && !move_rsp.unit_fault);
  endproperty
  a_combined_ctrl_flags_write_priv: assert property (p_combined_ctrl_flags_write_priv) else $error("combined flags write not faulted");

  property p_unit_check;
    @(posedge clk) disable iff (!rst_n)
      (move_req.valid && move_req.num <= AR_M_LAST && move_req.unit == UNIT_I)
      |-> ##2 (move_rsp.valid && move_rsp.unit_fault);
  endproperty
  a_unit_check: assert property (p_unit_check) else $error("wrong unit accepted");

  property p_ignored_any_unit;
    @(posedge clk) disable iff (!rst_n)
      (move_req.valid && move_req.num >= AR_IGN_HI_FIRST)
      |-> ##2 (move_rsp.valid && !move_rsp.unit_fault && !move_rsp.illegal_fault && move_rsp.rdata == REG_RESET);
  endproperty
  a_ignored_any_unit: assert property (p_ignored_any_unit) else $error("ignored number misbehaved");

  property p_lflags_protect;
    @(posedge clk) disable iff (!rst_n)
      (move_req.valid && move_req.write && move_req.unit == UNIT_M && move_req.num == AR_LFLAGS
       && cur_priv_level != PL_MOST && !engine_upd.valid)
      |=> ((lflags_r & LFLAGS_PRIV_MASK) == ($past(lflags_r) & LFLAGS_PRIV_MASK)) ##1 !move_rsp.priv_fault;
  endproperty
  a_lflags_protect: assert property (p_lflags_protect) else $error("protected legacy flag changed");

  property p_pl_clamp;
    @(posedge clk) disable iff (!rst_n)
      (move_req.valid && move_req.write && move_req.unit == UNIT_M && move_req.num == AR_RSC)
      |=> (engine_cfg.engine_priv_level >= $past(cur_priv_level));
  endproperty
  a_pl_clamp: assert property (p_pl_clamp) else $error("engine privilege above caller");

  property p_cfg_fields;
    @(posedge clk) disable iff (!rst_n)
      (move_req.valid && move_req.write && move_req.unit == UNIT_M && move_req.num == AR_RSC)
      |=> (engine_cfg.eager_load == $past(move_req.wdata[RSC_EAGER_LD_BIT])
           && engine_cfg.eager_store == $past(move_req.wdata[RSC_EAGER_ST_BIT])
           && engine_cfg.engine_byte_order == $past(move_req.wdata[RSC_BE_BIT])
           && engine_cfg.reload_distance == $past(move_req.wdata[RSC_RLD_MSB:RSC_RLD_LSB]));
  endproperty
  a_cfg_fields: assert property (p_cfg_fields) else $error("configuration field not taken");

  property p_rsc_reserved_zero;
    @(posedge clk) disable iff (!rst_n)
      (move_req.valid && !move_req.write && move_req.unit == UNIT_M && move_req.num == AR_RSC)
      |-> ##2 ((move_rsp.rdata & ~RSC_IMPL_MASK) == REG_RESET);
  endproperty
  a_rsc_reserved_zero: assert property (p_rsc_reserved_zero) else $error("reserved configuration bit set");

  property p_sap_read_only;
    @(posedge clk) disable iff (!rst_n)
      (move_req.valid && move_req.write && move_req.unit == UNIT_M && move_req.num == AR_SAP && !engine_upd.valid)
      |=> $stable(spill_area_pointer) ##1 move_rsp.illegal_fault;
  endproperty
  a_sap_read_only: assert property (p_sap_read_only) else $error("spill area pointer written by move");

  property p_kr_read_any_level;
    @(posedge clk) disable iff (!rst_n)
      (move_req.valid && !move_req.write && move_req.unit == UNIT_M && move_req.num <= AR_KR_LAST)
      |-> ##2 (move_rsp.valid && !move_rsp.unit_fault && !move_rsp.illegal_fault && !move_rsp.priv_fault);
  endproperty
  a_kr_read_any_level: assert property (p_kr_read_any_level) else $error("kernel info read refused");

  property p_cfg_hold;
    @(posedge clk) disable iff (!rst_n)
      !(move_req.valid && move_req.write && move_req.num == AR_RSC) |=> $stable(engine_cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("configuration changed without a write");

  property p_pl_taken;
    @(posedge clk) disable iff (!rst_n)
      (move_req.valid && move_req.write && move_req.unit == UNIT_M && move_req.num == AR_RSC
       && move_req.wdata[RSC_PL_MSB:RSC_PL_LSB] >= cur_priv_level)
      |=> (engine_cfg.engine_priv_level == $past(move_req.wdata[RSC_PL_MSB:RSC_PL_LSB]));
  endproperty
  a_pl_taken: assert property (p_pl_taken) else $error("engine privilege not taken as written");

  property p_cfg_read_back;
    @(posedge clk) disable iff (!rst_n)
      (move_req.valid && !move_req.write && move_req.unit == UNIT_M && move_req.num == AR_RSC)
      |-> ##2 (move_rsp.rdata[RSC_RLD_MSB:RSC_RLD_LSB] == $past(engine_cfg.reload_distance, 2)
               && move_rsp.rdata[RSC_BE_BIT] == $past(engine_cfg.engine_byte_order, 2));
  endproperty
  a_cfg_read_back: assert property (p_cfg_read_back) else $error("configuration read back differs");

  property p_sap_engine_only;
    @(posedge clk) disable iff (!rst_n)
      engine_upd.valid |=> (spill_area_pointer == $past(engine_upd.value));
  endproperty
  a_sap_engine_only: assert property (p_sap_engine_only) else $error("engine update not taken");

  property p_sap_hold;
    @(posedge clk) disable iff (!rst_n)
      !engine_upd.valid |=> $stable(spill_area_pointer);
  endproperty
  a_sap_hold: assert property (p_sap_hold) else $error("spill area pointer moved without engine");

endmodule // application_register_file

// ==== test/exec_unit_model.sv ====
// Execution unit model: issues register moves and collects their answers
`timescale 1ns/10ps
module exec_unit_model (
  input wire logic clk,
  output arf_pkg::move_req_t move_req,
  input arf_pkg::move_rsp_t move_rsp
);
  import arf_pkg::*;
  initial move_req = '0;
  // =====
  // Request helpers
  task automatic put(input logic wr, input exec_unit_t u, input logic [6:0] n, input logic [63:0] d);
    move_req <= '{valid: 1'b1, write: wr, unit: u, num: n, wdata: d};
  endtask
  // Idle fields flip so a stale request is never mistaken for a held one
  task automatic idle();
    move_req <= '{valid: 1'b0, write: ~move_req.write, unit: exec_unit_t'(~move_req.unit),
                  num: ~move_req.num, wdata: ~move_req.wdata};
  endtask
  // Taken at the edge after put; the answer stands for one cycle, from the next edge on
  task automatic do_move(input logic wr, input exec_unit_t u, input logic [6:0] n, input logic [63:0] d,
                         output move_rsp_t r);
    @(posedge clk);
    put(wr, u, n, d);
    @(posedge clk);
    idle();
    @(posedge clk);
    #1 r = move_rsp;
  endtask
  // Write, then read of the same number on the very next edge
  task automatic wr_rd(input exec_unit_t u, input logic [6:0] n, input logic [63:0] d,
                       output move_rsp_t rw, output move_rsp_t rr);
    @(posedge clk);
    put(1'b1, u, n, d);
    @(posedge clk);
    put(1'b0, u, n, ~d);
    @(posedge clk);
    idle();
    #1 rw = move_rsp;
    @(posedge clk);
    #1 rr = move_rsp;
  endtask
endmodule // exec_unit_model

// ==== test/testbench.sv ====
// Self-checking bench of the application register file
`timescale 1ns/10ps
module testbench;
  import arf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] cur_priv_level = 2'h0;
  logic legacy_active = 1'b0;
  legacy_wr_t legacy_wr = '0;
  engine_upd_t engine_upd = '0;
  move_req_t move_req;
  move_rsp_t move_rsp;
  move_rsp_t rw;
  move_rsp_t rr;
  engine_cfg_t engine_cfg;
  logic [63:0] spill_area_pointer;
  int num_errors = 0;
  int checks_done = 0;
  // Answer codes as {valid, unit, illegal, priv}
  localparam logic [3:0] OK = 4'h8;
  localparam logic [3:0] FU = 4'hc;
  localparam logic [3:0] FI = 4'ha;
  localparam logic [3:0] FP = 4'h9;

  always #4 clk = ~clk;

  application_register_file dut_u (.clk(clk), .rst_n(rst_n), .move_req(move_req),
    .cur_priv_level(cur_priv_level), .legacy_active(legacy_active), .legacy_wr(legacy_wr),
    .engine_upd(engine_upd), .move_rsp(move_rsp), .engine_cfg(engine_cfg),
    .spill_area_pointer(spill_area_pointer));
  exec_unit_model eu_u (.clk(clk), .move_req(move_req), .move_rsp(move_rsp));

  // =====
  // Tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic mvc(input logic wr, input exec_unit_t u, input logic [6:0] n, input logic [63:0] d,
                     input logic [3:0] ef, input logic [63:0] ed);
    move_rsp_t r;
    eu_u.do_move(wr, u, n, d, r);
    check({60'h0, r.valid, r.unit_fault, r.illegal_fault, r.priv_fault}, {60'h0, ef});
    check(r.rdata, ed);
  endtask
  task automatic ctl(input logic [1:0] pl, input logic leg);
    @(posedge clk);
    cur_priv_level <= pl;
    legacy_active <= leg;
  endtask
  task automatic finish_test();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Generous bound: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  // =====
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check(64'(engine_cfg), 64'h0);
    check(spill_area_pointer, 64'h0);
    for (int k = 0; k < 8; k++) begin
      ctl(2'h0, 1'b0);
      mvc(1'b1, UNIT_M, 7'(k), {32'hc0de_0000, 32'(k)}, OK, 64'h0);
      ctl(2'(k % 3 + 1), 1'b0);
      mvc(1'b1, UNIT_M, 7'(k), ALL_ONES, FP, 64'h0);
      mvc(1'b1, UNIT_I, 7'(k), ALL_ONES, FU, 64'h0);
      mvc(1'b0, UNIT_M, 7'(k), 64'h0, OK, {32'hc0de_0000, 32'(k)});
    end
    ctl(2'h0, 1'b0);
    mvc(1'b1, UNIT_M, AR_COMBINED_CTRL_FLAGS, 64'h5a, OK, 64'h0);
    ctl(2'h1, 1'b0);
    mvc(1'b1, UNIT_M, AR_COMBINED_CTRL_FLAGS, ALL_ONES, FP, 64'h0);
    ctl(2'h3, 1'b0);
    mvc(1'b0, UNIT_M, AR_COMBINED_CTRL_FLAGS, 64'h0, OK, 64'h5a);
    mvc(1'b1, UNIT_I, AR_RSC, 64'h0, FU, 64'h0);
    mvc(1'b0, UNIT_M, AR_PFS, 64'h0, FU, 64'h0);
    mvc(1'b0, UNIT_I, AR_ITC, 64'h0, FU, 64'h0);
    mvc(1'b1, UNIT_M, AR_IGN_LO_FIRST, ALL_ONES, OK, 64'h0);
    mvc(1'b0, UNIT_I, AR_IGN_LO_LAST, 64'h0, OK, 64'h0);
    mvc(1'b1, UNIT_I, 7'h7f, ALL_ONES, OK, 64'h0);
    mvc(1'b0, UNIT_M, AR_IGN_HI_FIRST, 64'h0, OK, 64'h0);
    mvc(1'b0, UNIT_M, 7'h08, 64'h0, FI, 64'h0);
    mvc(1'b1, UNIT_I, AR_EPC, ALL_ONES, OK, 64'h0);
    mvc(1'b0, UNIT_I, AR_EPC, 64'h0, OK, EC_MASK);
    // Protected flag bits survive a low-privilege clear
    ctl(2'h0, 1'b0);
    mvc(1'b1, UNIT_M, AR_LFLAGS, ALL_ONES, OK, 64'h0);
    ctl(2'h3, 1'b0);
    mvc(1'b1, UNIT_M, AR_LFLAGS, 64'h0, OK, 64'h0);
    mvc(1'b0, UNIT_M, AR_LFLAGS, 64'h0, OK, LFLAGS_PRIV_MASK);
    ctl(2'h0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      legacy_wr <= '{valid: 1'b1, idx: 2'(i), data: {32'hbeef_0000, 32'(i)}};
    end
    @(posedge clk);
    legacy_wr <= '{valid: 1'b0, idx: 2'h3, data: ALL_ONES};
    // Moves still answer while legacy code runs, but leave storage alone
    mvc(1'b1, UNIT_M, 7'h3, ALL_ONES, OK, 64'h0);
    ctl(2'h0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      mvc(1'b0, UNIT_M, 7'(i), 64'h0, OK, {32'hbeef_0000, 32'(i)});
    end
    mvc(1'b0, UNIT_M, 7'h3, 64'h0, OK, 64'hc0de_0000_0000_0003);
    mvc(1'b1, UNIT_M, AR_RSC, ALL_ONES, OK, 64'h0);
    mvc(1'b0, UNIT_M, AR_RSC, 64'h0, OK, RSC_IMPL_MASK);
    check(64'(engine_cfg), 64'h7ffff);
    for (int m = 0; m < 4; m++) begin
      mvc(1'b1, UNIT_M, AR_RSC, 64'h1555_0010 | 64'(m), OK, 64'h0);
      check(64'(engine_cfg), {45'h0, m[1], m[0], 2'h0, 1'b1, 14'h1555});
    end
    mvc(1'b1, UNIT_M, AR_RSC, 64'h2aaa_0000, OK, 64'h0);
    check(64'(engine_cfg), 64'h2aaa);
    ctl(2'h2, 1'b0);
    mvc(1'b1, UNIT_M, AR_RSC, 64'h4, OK, 64'h0);
    check(64'(engine_cfg), 64'h1_0000);
    mvc(1'b0, UNIT_M, AR_RSC, 64'h0, OK, 64'h8);
    mvc(1'b1, UNIT_M, AR_RSC, 64'hc, OK, 64'h0);
    check(64'(engine_cfg), 64'h1_8000);
    ctl(2'h0, 1'b0);
    @(posedge clk);
    engine_upd <= '{valid: 1'b1, value: 64'h0123_4567_89ab_cdef};
    @(posedge clk);
    engine_upd <= '{valid: 1'b0, value: 64'hfedc_ba98_7654_3210};
    mvc(1'b1, UNIT_M, AR_SAP, 64'h0, FI, 64'h0);
    mvc(1'b0, UNIT_M, AR_SAP, 64'h0, OK, 64'h0123_4567_89ab_cdef);
    check(spill_area_pointer, 64'h0123_4567_89ab_cdef);
    eu_u.wr_rd(UNIT_M, 7'h5, 64'h0f1e_2d3c_4b5a_6978, rw, rr);
    check({63'h0, rw.valid}, 64'h1);
    check(rr.rdata, 64'h0f1e_2d3c_4b5a_6978);
    finish_test();
  end
endmodule // testbench
